/* File: common/iox_pkg.sv */
// constants and types shared by the sixteen-pin expander
package iox_pkg;
  localparam logic [3:0] ADDR_HI = 4'h4;
  localparam int ADDR_SEL_W = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] GRP_IN = 2'h0;
  localparam logic [1:0] GRP_OUT = 2'h1;
  localparam logic [1:0] GRP_POL = 2'h2;
  localparam logic [1:0] GRP_CFG = 2'h3;
  localparam logic [2:0] CMD_RST = 3'h0;
  localparam logic [15:0] OUT_RST = 16'hFFFF;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hFFFF;
  // cycles after reset until the synchronised pins show real levels
  localparam logic [2:0] SYNC_SETTLE = 3'h4;
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_CMD = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam int CLK_HZ = 100000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam int SCL_MIN_PERIOD_CYC = (CLK_HZ + SCL_MAX_HZ - 1) / SCL_MAX_HZ;
  typedef enum logic [4:0] {
    IOX_IDLE = 5'h01,
    IOX_RX = 5'h02,
    IOX_ACK = 5'h04,
    IOX_TX = 5'h08,
    IOX_MACK = 5'h10
  } iox_state_t;
endpackage : iox_pkg

/* File: design/iox_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module iox_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] q_r;
  wire logic [WIDTH-1:0] differ = s2_r ^ s3_r;
  wire logic [WIDTH-1:0] q_nxt = (s3_r & ~differ) | (q_r & differ);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : iox_sync

/* File: design/iox_top.sv */
// two-wire serial slave with sixteen-pin i/o ports and change interrupt
//
// Function
// RULE_01 - all sixteen pins are inputs after reset
// RULE_02 - two 8-bit registers per function
// RULE_03 - per-pin direction bit written by master
// RULE_04 - polarity bit inverts captured input level
// RULE_05 - every register readable over serial bus
// RULE_06 - reset restores defaults and bus machine
// RULE_07 - interrupt when input differs from capture
// RULE_08 - interrupt is active-low open drain
// RULE_09 - three pins set low address bits
// RULE_10 - input pins have both drivers off
// RULE_11 - output pins driven from output register
// RULE_12 - master keeps serial clock at most 400kHz; the bench master runs it at 6.25MHz (160 ns per bit)
// RULE_13 - answer addresses 0x20-0x27, last bit read/write
// RULE_14 - command low three bits select register
// RULE_15 - last command kept for later reads
// RULE_16 - input register writes ignored, shows pins
// RULE_17 - direction bit one means input
// RULE_18 - interrupt cleared by match or port read
`timescale 1ns/1ps
module iox_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit2,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_n,
  output logic int_out,
  output logic int_oe_n
);
  localparam int SYNC_W = 21;
  localparam logic [SYNC_W-1:0] SYNC_RST = {2'h3, 19'h00000};

  wire logic [SYNC_W-1:0] sync_q;
  iox_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in, addr_sel_bit2, addr_sel_bit1, addr_sel_bit0, port_b_in, port_a_in}),
    .q(sync_q)
  );

  wire logic scl_f = sync_q[20];
  wire logic sda_f = sync_q[19];
  wire logic [2:0] addr_f = sync_q[18:16];
  wire logic [15:0] pins_f = sync_q[15:0];

  iox_pkg::iox_state_t state_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [1:0] kind_r;
  logic rw_r;
  logic mack_r;
  logic sda_oe_n_r;
  logic [2:0] cmd_r;
  logic [15:0] out_r;
  logic [15:0] pol_r;
  logic [15:0] cfg_r;
  logic [15:0] snap_r;
  logic snap_vld_r;
  logic int_oe_n_r;
  logic [2:0] settle_r;

  // edges and bus conditions on the filtered lines
  wire logic scl_rise = scl_f & ~scl_prev_r;
  wire logic scl_fall = ~scl_f & scl_prev_r;
  wire logic start_det = scl_f & scl_prev_r & sda_prev_r & ~sda_f;
  wire logic stop_det = scl_f & scl_prev_r & ~sda_prev_r & sda_f;
  wire logic in_rx = (state_r == iox_pkg::IOX_RX);
  wire logic byte_done = in_rx & scl_fall & (bitcnt_r == iox_pkg::BITS_PER_BYTE);
  wire logic addr_hit = (shift_r[7:1] == {iox_pkg::ADDR_HI, addr_f}); // RULE_09 RULE_13
  wire logic addr_done = byte_done & (kind_r == iox_pkg::KIND_ADDR);
  wire logic cmd_done = byte_done & (kind_r == iox_pkg::KIND_CMD);
  wire logic wr_done = byte_done & (kind_r == iox_pkg::KIND_DATA);
  wire logic ack_end = (state_r == iox_pkg::IOX_ACK) & scl_fall;
  wire logic mack_end = (state_r == iox_pkg::IOX_MACK) & scl_fall;
  wire logic tx_load = (ack_end & rw_r) | (mack_end & mack_r);

  // read selection
  wire logic [1:0] rd_grp = cmd_r[2:1];
  wire logic rd_port = cmd_r[0];
  wire logic [15:0] live = pins_f ^ pol_r; // RULE_04 RULE_16
  wire logic [15:0] sel16 = (rd_grp == iox_pkg::GRP_IN) ? live :
                            (rd_grp == iox_pkg::GRP_OUT) ? out_r :
                            (rd_grp == iox_pkg::GRP_POL) ? pol_r : cfg_r; // RULE_05 RULE_14
  wire logic [7:0] rd_byte = rd_port ? sel16[15:8] : sel16[7:0];
  wire logic rd_in_load = tx_load & (rd_grp == iox_pkg::GRP_IN);
  wire logic [1:0] wr_grp = cmd_r[2:1];

  // only pins set as inputs can raise the interrupt
  wire logic [15:0] diff = (live ^ snap_r) & cfg_r;
  wire logic int_nxt = snap_vld_r & (|diff);
  wire logic settle_done = (settle_r == iox_pkg::SYNC_SETTLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_f;
      sda_prev_r <= sda_f;
    end
  end

  // bus state machine; start and stop override any state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= iox_pkg::IOX_IDLE; // RULE_06
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      kind_r <= iox_pkg::KIND_ADDR;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (start_det) begin
      state_r <= iox_pkg::IOX_RX;
      bitcnt_r <= 4'h0;
      kind_r <= iox_pkg::KIND_ADDR;
      sda_oe_n_r <= 1'b1;
    end else if (stop_det) begin
      state_r <= iox_pkg::IOX_IDLE;
      sda_oe_n_r <= 1'b1;
    end else if (tx_load) begin
      state_r <= iox_pkg::IOX_TX; // RULE_05
      shift_r <= rd_byte;
      sda_oe_n_r <= rd_byte[7];
      bitcnt_r <= 4'h1;
    end else begin
      unique case (state_r)
        iox_pkg::IOX_IDLE: begin
        end
        iox_pkg::IOX_RX: begin
          if (scl_rise && bitcnt_r != iox_pkg::BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], sda_f};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (byte_done) begin
            if (kind_r == iox_pkg::KIND_ADDR && !addr_hit) begin
              state_r <= iox_pkg::IOX_IDLE; // RULE_13
            end else begin
              state_r <= iox_pkg::IOX_ACK;
              sda_oe_n_r <= 1'b0;
              bitcnt_r <= 4'h0;
              if (kind_r == iox_pkg::KIND_ADDR) begin
                rw_r <= shift_r[0]; // RULE_13
                kind_r <= shift_r[0] ? iox_pkg::KIND_DATA : iox_pkg::KIND_CMD;
              end else begin
                kind_r <= iox_pkg::KIND_DATA;
              end
            end
          end
        end
        iox_pkg::IOX_ACK: begin
          if (scl_fall) begin
            state_r <= iox_pkg::IOX_RX;
            sda_oe_n_r <= 1'b1;
          end
        end
        iox_pkg::IOX_TX: begin
          if (scl_fall) begin
            if (bitcnt_r == iox_pkg::BITS_PER_BYTE) begin
              state_r <= iox_pkg::IOX_MACK;
              sda_oe_n_r <= 1'b1;
              bitcnt_r <= 4'h0;
            end else begin
              shift_r <= {shift_r[6:0], 1'b1};
              sda_oe_n_r <= shift_r[6];
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        iox_pkg::IOX_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_f;
          end else if (scl_fall) begin
            state_r <= iox_pkg::IOX_IDLE;
          end
        end
      endcase
    end
  end

  // command and register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_r <= iox_pkg::CMD_RST; // RULE_06
      out_r <= iox_pkg::OUT_RST;
      pol_r <= iox_pkg::POL_RST;
      cfg_r <= iox_pkg::CFG_RST; // RULE_01 RULE_17
    end else if (cmd_done) begin
      cmd_r <= shift_r[2:0]; // RULE_14 RULE_15
    end else if (wr_done) begin
      if (wr_grp == iox_pkg::GRP_OUT) begin
        out_r[rd_port*8 +: 8] <= shift_r; // RULE_02
      end
      if (wr_grp == iox_pkg::GRP_POL) begin
        pol_r[rd_port*8 +: 8] <= shift_r;
      end
      if (wr_grp == iox_pkg::GRP_CFG) begin
        cfg_r[rd_port*8 +: 8] <= shift_r; // RULE_03
      end
    end
  end

  // snapshot taken at start and at each read of an input register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_r <= 16'h0000;
      snap_vld_r <= 1'b0;
      settle_r <= 3'h0;
      int_oe_n_r <= 1'b1;
    end else begin
      int_oe_n_r <= ~int_nxt; // RULE_07 RULE_18
      if (!snap_vld_r) begin
        // synchronised pins restart at zero; a snapshot taken early would raise a false change
        snap_r <= live;
        snap_vld_r <= settle_done;
        settle_r <= settle_r + 3'h1;
      end else if (rd_in_load) begin
        snap_r[rd_port*8 +: 8] <= live[rd_port*8 +: 8]; // RULE_18
      end
    end
  end

  // drivers: oe_n high releases the pin, so input pins float
  assign port_a_out = out_r[7:0]; // RULE_11
  assign port_b_out = out_r[15:8];
  assign port_a_oe_n = cfg_r[7:0]; // RULE_10
  assign port_b_oe_n = cfg_r[15:8];
  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign int_out = 1'b0; // RULE_08
  assign int_oe_n = int_oe_n_r;

  sequence s_addr_match;
    addr_done && addr_hit;
  endsequence
  sequence s_ack_driven;
    (state_r == iox_pkg::IOX_ACK) && !sda_oe_n;
  endsequence

  property p_reset_inputs;
    @(posedge clk) $rose(rst_n) |-> (port_a_oe_n == 8'hFF) && (port_b_oe_n == 8'hFF);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset"); // RULE_01
  property p_reset_bus;
    @(posedge clk) $rose(rst_n) |-> (state_r == iox_pkg::IOX_IDLE) && sda_oe_n
      && (port_a_out == 8'hFF) && (cmd_r == 3'h0);
  endproperty
  a_reset_bus: assert property (p_reset_bus) else $error("reset state wrong"); // RULE_06
  property p_addr_ack;
    @(posedge clk) disable iff (!rst_n) s_addr_match |=> s_ack_driven;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked"); // RULE_13
  property p_addr_miss;
    @(posedge clk) disable iff (!rst_n)
      addr_done && !addr_hit && !start_det && !stop_det |=> (state_r == iox_pkg::IOX_IDLE) && sda_oe_n;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered"); // RULE_09
  property p_cmd_hold;
    @(posedge clk) disable iff (!rst_n) !cmd_done |=> $stable(cmd_r);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without byte"); // RULE_15
  property p_in_write_ignored;
    @(posedge clk) disable iff (!rst_n) wr_done && (wr_grp == iox_pkg::GRP_IN)
      |=> $stable(out_r) && $stable(pol_r) && $stable(cfg_r);
  endproperty
  a_in_write_ignored: assert property (p_in_write_ignored) else $error("input write had effect"); // RULE_16
  property p_cfg_write;
    @(posedge clk) disable iff (!rst_n) wr_done && (cmd_r == 3'h6)
      |=> port_a_oe_n == $past(shift_r);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("direction write lost"); // RULE_10
  property p_out_write;
    @(posedge clk) disable iff (!rst_n) wr_done && (cmd_r == 3'h3)
      |=> port_b_out == $past(shift_r);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output write lost"); // RULE_11
  property p_read_inverted;
    @(posedge clk) disable iff (!rst_n) tx_load && !start_det && !stop_det && (cmd_r == 3'h0)
      |=> shift_r == ($past(pins_f[7:0]) ^ $past(pol_r[7:0]));
  endproperty
  a_read_inverted: assert property (p_read_inverted) else $error("input read not inverted"); // RULE_04
  property p_int_follows;
    @(posedge clk) disable iff (!rst_n) ##1 int_oe_n == !$past(int_nxt);
  endproperty
  a_int_follows: assert property (p_int_follows) else $error("interrupt not tracking change"); // RULE_07
  property p_int_od;
    @(posedge clk) disable iff (!rst_n) !int_oe_n |-> !int_out;
  endproperty
  a_int_od: assert property (p_int_od) else $error("interrupt drives high"); // RULE_08
  property p_read_clears;
    @(posedge clk) disable iff (!rst_n) rd_in_load && snap_vld_r && !start_det && !stop_det
      && !rd_port |=> snap_r[7:0] == $past(live[7:0]);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not refresh capture"); // RULE_18
endmodule : iox_top

/* File: test/iox_master.sv */
// two-wire bus master model for the expander
`timescale 1ns/1ps
module iox_master (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_lo
);
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // 10 low + 6 high cycles = 160 ns; data moves mid-low so hold covers the input filter
  task automatic bit_io(input logic b, output logic got);
    repeat (5) @(negedge clk);
    sda_lo = ~b;
    repeat (5) @(negedge clk);
    scl = 1'b1;
    repeat (6) @(negedge clk);
    got = sda_w;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    repeat (5) @(negedge clk);
    sda_lo = 1'b0;
    repeat (5) @(negedge clk);
    scl = 1'b1;
    repeat (6) @(negedge clk);
    sda_lo = 1'b1;
    repeat (6) @(negedge clk);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    repeat (5) @(negedge clk);
    sda_lo = 1'b1;
    repeat (5) @(negedge clk);
    scl = 1'b1;
    repeat (6) @(negedge clk);
    sda_lo = 1'b0;
    repeat (6) @(negedge clk);
  endtask : stop
  task automatic put(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(d[i], g);
    bit_io(1'b1, g);
    ack = ~g;
  endtask : put
  task automatic get(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, g);
      d[i] = g;
    end
    // last byte: release the line so the slave sees no acknowledge
    bit_io(last, g);
  endtask : get
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic has_d, output logic ok);
    logic k0, k1, k2;
    start();
    put({a, 1'b0}, k0);
    put(c, k1);
    k2 = 1'b1;
    if (has_d) put(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    start();
    put({a, 1'b1}, ok);
    get(1'b1, d);
    stop();
  endtask : rd
endmodule : iox_master

/* File: test/iox_top_tb_top.sv */
// self-checking bench for the sixteen-pin expander
`timescale 1ns/1ps
module iox_top_tb_top;
  typedef struct packed { logic [7:0] cmd, wd, exp; } iox_row_t;
  logic clk, rst_n, scl, sda_lo, sda_oe_n, int_oe_n, ok;
  logic [2:0] asel;
  logic [7:0] pa_ext, pb_ext, pa_out, pa_oe_n, pb_out, pb_oe_n, rd_d;
  int error_cnt, compares;
  wire sda_o, int_o;
  // open-drain lines: low only where a side enables its low drive
  wire sda_w = ~sda_lo & (sda_oe_n | sda_o);
  wire int_ln = int_oe_n | int_o;
  wire [6:0] adr = {4'h4, asel};
  // pin level: device drives where enabled, outside world elsewhere
  wire [7:0] pa_pin = (pa_oe_n & pa_ext) | (~pa_oe_n & pa_out);
  wire [7:0] pb_pin = (pb_oe_n & pb_ext) | (~pb_oe_n & pb_out);
  iox_row_t rows [8] = '{'{8'hF2, 8'h5A, 8'h5A}, '{8'h03, 8'hC3, 8'hC3},
    '{8'h04, 8'h0F, 8'h0F}, '{8'h05, 8'hF0, 8'hF0}, '{8'h06, 8'h00, 8'h00},
    '{8'h07, 8'h55, 8'h55}, '{8'h00, 8'hAA, 8'h55}, '{8'h01, 8'h00, 8'h73}};
  iox_top dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_n(sda_oe_n), .addr_sel_bit0(asel[0]), .addr_sel_bit1(asel[1]),
    .addr_sel_bit2(asel[2]), .port_a_in(pa_pin), .port_a_out(pa_out),
    .port_a_oe_n(pa_oe_n), .port_b_in(pb_pin), .port_b_out(pb_out),
    .port_b_oe_n(pb_oe_n), .int_out(int_o), .int_oe_n(int_oe_n));
  iox_master m (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_lo(sda_lo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_int(input logic v);
    for (int i = 0; i < 12 && int_ln !== v; i++) @(negedge clk);
    chk({7'h0, int_ln}, {7'h0, v}, "int line");
  endtask : wait_int
  task automatic do_rst();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : do_rst
  task automatic chk_rst();
    chk(pa_oe_n, 8'hFF, "dir a");
    chk(pb_oe_n, 8'hFF, "dir b");
    chk(pa_out, 8'hFF, "out a");
    chk(pb_out, 8'hFF, "out b");
    chk({7'h0, int_ln}, 8'h01, "int idle");
  endtask : chk_rst
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    error_cnt = 0;
    compares = 0;
    asel = 3'h5;
    pa_ext = 8'h3C;
    pb_ext = 8'h81;
    do_rst();
    chk_rst();
    foreach (rows[i]) begin
      m.wr(adr, rows[i].cmd, rows[i].wd, 1'b1, ok);
      chk({7'h0, ok}, 8'h01, "write ack");
      m.rd(adr, rd_d, ok);
      chk(rd_d, rows[i].exp, "readback");
    end
    chk(pa_out, 8'h5A, "out a");
    chk(pa_oe_n, 8'h00, "dir a");
    chk(pb_out, 8'hC3, "out b");
    chk(pb_oe_n, 8'h55, "dir b");
    wait_int(1'b1);
    $display("end of table test");
    // only pin 0 of port b is both an input and changed here
    pb_ext = 8'h80;
    wait_int(1'b0);
    pb_ext = 8'h81;
    wait_int(1'b1);
    pb_ext = 8'h80;
    wait_int(1'b0);
    m.wr(adr, 8'h01, 8'h00, 1'b0, ok);
    m.rd(adr, rd_d, ok);
    chk(rd_d, 8'h72, "input b");
    // two-byte read: master acks the first, both bytes come from one register
    m.start();
    m.put({adr, 1'b1}, ok);
    chk({7'h0, ok}, 8'h01, "read ack");
    m.get(1'b0, rd_d);
    chk(rd_d, 8'h72, "read byte 1");
    m.get(1'b1, rd_d);
    chk(rd_d, 8'h72, "read byte 2");
    m.stop();
    wait_int(1'b1);
    $display("end of interrupt test");
    for (int a = 0; a < 8; a++) begin
      asel = a[2:0];
      repeat (8) @(negedge clk);
      m.start();
      m.put({4'h4, a[2:0], 1'b0}, ok);
      m.stop();
      chk({7'h0, ok}, 8'h01, "addr ack");
      m.start();
      m.put({4'h4, ~a[2:0], 1'b0}, ok);
      m.stop();
      chk({7'h0, ok}, 8'h00, "addr nack");
    end
    $display("end of address test");
    // reset lands mid-frame; the bus machine must restart cleanly
    m.start();
    m.put({adr, 1'b0}, ok);
    do_rst();
    m.stop();
    chk_rst();
    m.wr(adr, 8'h07, 8'h00, 1'b0, ok);
    m.rd(adr, rd_d, ok);
    chk(rd_d, 8'hFF, "dir b default");
    m.wr(adr, 8'h04, 8'h00, 1'b0, ok);
    m.rd(adr, rd_d, ok);
    chk(rd_d, 8'h00, "pol a default");
    $display("end of reset test");
    report_and_stop();
  end
endmodule : iox_top_tb_top
